// ### core/tmpi_pkg.sv
// Purpose: Shared constants for the test-mode programming interface.
// Assumes: 200 MHz core clock, 58-bit configuration word, AHB-Lite registers.
// Notes: Field positions follow the configuration word layout.
package tmpi_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CFG_LO = 8'h00; // Config bits 31:0
  localparam logic [7:0] REG_CFG_HI = 8'h04; // Config bits 57:32
  localparam logic [7:0] REG_STATUS = 8'h08; // Session state
  localparam logic [7:0] REG_LIMITS = 8'h0c; // Held calibration limits
  // Configuration word
  localparam int CFG_W = 58; // Total bits
  localparam int SETUP_LO = 36; // Lowest bit loaded by setup mode
  localparam int SETUP_BITS = 22; // Bits loaded by setup mode
  localparam int NL_POS = 30; // Normal limit
  localparam int HYL_POS = 24; // Hysteresis limit
  localparam int HUL_POS = 18; // Hush limit
  localparam int CTL_POS = 12; // Chamber test limit
  localparam int NAM_POS = 6; // Alarm maximum
  localparam int LTDV_POS = 0; // Drift baseline
  localparam int LTD_EN_POS = 50; // Drift enable
  localparam int LIM_W = 6; // Converter width
  localparam logic [CFG_W-1:0] CFG_RESET = 58'h0; // Image after reset
  // Modes
  localparam logic [3:0] MODE_HORN = 4'h0;
  localparam logic [3:0] MODE_BATT = 4'h1;
  localparam logic [3:0] MODE_SETUP = 4'h2;
  localparam logic [3:0] MODE_LIM_FIRST = 4'h3;
  localparam logic [3:0] MODE_LIM_MAX = 4'h7;
  localparam logic [3:0] MODE_SERIAL = 4'h8;
  localparam logic [3:0] MODE_BASE = 4'h9;
  localparam logic [3:0] MODE_CHK_FIRST = 4'ha;
  localparam logic [3:0] MODE_LAST = 4'he;
  // Programming pulse train
  localparam logic [3:0] PROG_PULSES = 4'ha; // Pulses before commit
  localparam int PULSE_NS = 5000000; // Least high time, 5 ms
  localparam int CLK_NS = 5; // Clock period
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Session states
  typedef enum logic [1:0] {
    SES_OFF = 2'b01,
    SES_ON = 2'b10
  } tmpi_ses_t;
endpackage : tmpi_pkg

// ### core/tmpi_top.sv
// Purpose: Test-mode sequencer and serial configuration loader.
// Assumes: Pin levels arrive as digital comparator outputs, asynchronous.
// Notes: Nonvolatile image is modelled as flops, also reachable over AHB-Lite.
// Summary of operation
// - Test operation only while mode select held
// - Boost swing clocks modes, battery level is data
// - Each test clock advances mode, up to 14
// - Feed, interconnect in; LEDs, horn out
// - Horn mode: horn follows enabling level
// - Battery mode: LEDs on, strobe enables boost
// - Setup mode shifts bits 36 to 57
// - Ten 5 ms pulses commit setup bits
// - Serial mode loads 58 bits, reads back
// - Limit modes: feed steps DAC, comparator shown
// - Comparator high when DAC below integrator
// - Interconnect edge integrates or latches limit
// - Limits held until alarm-max program enable
// - Two pulses: latch then store limits
// - Check modes compare measurement against limit
// - Error flag after enable falls, until mode left
// - Error when hysteresis not below normal
// - Error when drift on, maximum not above normal
// - Six-bit ramp converter from counter, DAC
// - Dropping mode select discards shifted bits
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module tmpi_top #(
  parameter int PULSE_MIN = tmpi_pkg::PULSE_CYC // Least pulse high time, cycles
) (
  input wire logic I_CLOCK, // Core clock
  input wire logic I_RESET_N, // Asynchronous reset, active low
  input wire logic I_MODE_SELECT_PIN, // Mode select at battery level
  input wire logic I_TEST_BOOST, // Test pin at boost level
  input wire logic I_TEST_DATA, // Test pin at battery level or above
  input wire logic I_FEED, // Feed pin
  input wire logic I_IO, // Interconnect pin
  input wire logic I_BATTERY_COMPARATOR_OUT, // Low battery comparator
  input wire logic [tmpi_pkg::LIM_W-1:0] I_INTEGRATOR_OUTPUT, // Integrator level code
  output logic O_RED_INDICATOR_OUT, // Red LED drive
  output logic O_GREEN_INDICATOR_OUT, // Green LED drive
  output logic O_HORN_DRIVE_OUT, // Horn pin
  output logic O_ERROR_FLAG_PIN, // Error flag
  output logic O_BOOST_ENABLE, // Boost converter request
  output logic O_ANALOG_VIEW, // LEDs carry DAC and integrator
  output logic [tmpi_pkg::LIM_W-1:0] O_DAC_LEVEL, // DAC code
  output logic O_INTEGRATE_START, // Start of integration, pulse
  output logic O_NVM_WRITE, // Image committed, pulse
  input wire logic I_HSEL, // AHB select
  input wire logic [31:0] I_HADDR, // AHB address
  input wire logic [1:0] I_HTRANS, // AHB transfer type
  input wire logic I_HWRITE, // AHB direction
  input wire logic [2:0] I_HSIZE, // AHB size
  input wire logic [31:0] I_HWDATA, // AHB write data
  input wire logic I_HREADY, // AHB bus ready
  output logic [31:0] O_HRDATA, // AHB read data
  output logic O_HREADYOUT, // AHB slave ready
  output logic O_HRESP // AHB response
);
  import tmpi_pkg::*;

  // Refuse a pulse limit the high-time counter cannot serve
  if (PULSE_MIN < 1) begin : g_bad_pulse
    $error("PULSE_MIN must be at least one cycle");
  end

  // Reset release through two flops
  logic rst_s1_reg, rst_n;
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // Pin synchronisers, two flops per bit, then a third for edges
  localparam int SYN_W = 6 + LIM_W;
  logic [SYN_W-1:0] pin_raw, syn1_reg, syn2_reg, prev_reg;
  assign pin_raw = {I_MODE_SELECT_PIN, I_TEST_BOOST, I_TEST_DATA, I_FEED, I_IO,
                    I_BATTERY_COMPARATOR_OUT, I_INTEGRATOR_OUTPUT};
  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
          syn1_reg[gi] <= 1'b0;
          syn2_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else begin
          syn1_reg[gi] <= pin_raw[gi];
          syn2_reg[gi] <= syn1_reg[gi];
          prev_reg[gi] <= syn2_reg[gi];
        end
      end
    end
  endgenerate
  logic msel, tclk_rise, tdata, feed, feed_rise, io_rise, io_fall, batt_low;
  logic [LIM_W-1:0] integ;
  assign msel = syn2_reg[SYN_W-1];
  assign tclk_rise = syn2_reg[SYN_W-2] & ~prev_reg[SYN_W-2];
  assign tdata = syn2_reg[SYN_W-3];
  assign feed = syn2_reg[SYN_W-4];
  assign feed_rise = feed & ~prev_reg[SYN_W-4];
  assign io_rise = syn2_reg[LIM_W+1] & ~prev_reg[LIM_W+1];
  assign io_fall = ~syn2_reg[LIM_W+1] & prev_reg[LIM_W+1];
  assign batt_low = syn2_reg[LIM_W];
  assign integ = syn2_reg[LIM_W-1:0];

  // Session state: on only while mode select stays high
  tmpi_ses_t ses_reg, ses_next;
  always_comb begin
    case (ses_reg)
      SES_OFF: ses_next = msel ? SES_ON : SES_OFF;
      SES_ON: ses_next = msel ? SES_ON : SES_OFF;
      default: ses_next = SES_OFF;
    endcase
  end
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) ses_reg <= SES_OFF;
    else ses_reg <= ses_next;
  end
  logic active;
  assign active = (ses_reg == SES_ON) && msel;

  // Mode counter, saturates at the last mode
  logic [3:0] mode_reg;
  logic mode_step;
  assign mode_step = active && tclk_rise && (mode_reg != MODE_LAST);
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) mode_reg <= MODE_HORN;
    else if (!active) mode_reg <= MODE_HORN;
    else if (mode_step) mode_reg <= mode_reg + 4'h1;
  end
  logic leave; // Current mode is being left
  assign leave = mode_step || (ses_reg == SES_ON && !msel);
  logic in_lim, in_chk, in_meas;
  assign in_lim = active && mode_reg >= MODE_LIM_FIRST && mode_reg <= MODE_LIM_MAX;
  assign in_chk = active && mode_reg >= MODE_CHK_FIRST;
  assign in_meas = in_chk || (active && mode_reg == MODE_BASE);

  // Configuration shift register, MSB first
  logic [CFG_W-1:0] shift_reg, nvm_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) shift_reg <= CFG_RESET;
    else if (!active) shift_reg <= CFG_RESET;
    else if (mode_step && mode_reg + 4'h1 == MODE_SERIAL) shift_reg <= nvm_reg;
    else if (feed_rise && (mode_reg == MODE_SETUP || mode_reg == MODE_SERIAL))
      shift_reg <= {shift_reg[CFG_W-2:0], tdata};
  end

  // Setup commit: count long enough interconnect pulses
  logic [31:0] hi_cnt_reg;
  logic [3:0] pulse_cnt_reg;
  logic setup_commit;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) hi_cnt_reg <= 32'h0;
    else if (!syn2_reg[LIM_W+1]) hi_cnt_reg <= 32'h0;
    else if (hi_cnt_reg < 32'(PULSE_MIN)) hi_cnt_reg <= hi_cnt_reg + 32'h1;
  end
  assign setup_commit = active && mode_reg == MODE_SETUP && io_fall &&
                        hi_cnt_reg >= 32'(PULSE_MIN) && pulse_cnt_reg == PROG_PULSES - 4'h1;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) pulse_cnt_reg <= 4'h0;
    else if (leave || !active) pulse_cnt_reg <= 4'h0;
    else if (setup_commit) pulse_cnt_reg <= 4'h0;
    else if (mode_reg == MODE_SETUP && io_fall && hi_cnt_reg >= 32'(PULSE_MIN))
      pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
  end

  // DAC counter: stepped in limit modes, ramped in measurement
  logic [LIM_W-1:0] dac_reg;
  logic smk_cmp, meas_run_reg, meas_done_reg, meas_start;
  assign smk_cmp = dac_reg < integ;
  assign meas_start = in_meas && feed_rise;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) dac_reg <= '0;
    else if (leave || meas_start) dac_reg <= '0;
    else if (in_lim && feed_rise && dac_reg != '1) dac_reg <= dac_reg + 6'h1;
    else if (meas_run_reg && smk_cmp && dac_reg != '1) dac_reg <= dac_reg + 6'h1;
  end
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      meas_run_reg <= 1'b0;
      meas_done_reg <= 1'b0;
    end else if (leave || meas_start) begin
      meas_run_reg <= meas_start && !leave;
      meas_done_reg <= 1'b0;
    end else if (meas_run_reg && (!smk_cmp || dac_reg == '1)) begin
      meas_run_reg <= 1'b0;
      meas_done_reg <= 1'b1;
    end
  end

  // Held limits and the two-pulse store in alarm-max mode
  logic [LIM_W-1:0] lim_reg [5];
  logic lim_latch, pend_reg, lim_store;
  logic [2:0] lim_idx;
  assign lim_latch = in_lim && io_rise && !feed;
  assign lim_idx = 3'(mode_reg - MODE_LIM_FIRST);
  assign lim_store = lim_latch && mode_reg == MODE_LIM_MAX && pend_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 5; k++) lim_reg[k] <= '0;
    end else if (lim_latch) begin
      lim_reg[lim_idx] <= dac_reg;
    end
  end
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) pend_reg <= 1'b0;
    else if (leave || !in_lim) pend_reg <= 1'b0;
    else if (io_rise) pend_reg <= !feed && mode_reg == MODE_LIM_MAX && !pend_reg;
  end
  logic integ_start_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) integ_start_reg <= 1'b0;
    else integ_start_reg <= (in_lim && io_rise && feed) || meas_start;
  end

  // Nonvolatile image: hardware commits win over software writes
  logic ser_commit, base_store, sw_wr_lo, sw_wr_hi;
  logic [31:0] sw_wdata;
  assign ser_commit = active && mode_reg == MODE_SERIAL && io_rise;
  assign base_store = active && mode_reg == MODE_BASE && io_rise;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      nvm_reg <= CFG_RESET;
    end else if (setup_commit) begin
      nvm_reg[CFG_W-1:SETUP_LO] <= shift_reg[SETUP_BITS-1:0];
    end else if (ser_commit) begin
      nvm_reg <= shift_reg;
    end else if (lim_store) begin
      nvm_reg[NL_POS +: LIM_W] <= lim_reg[0];
      nvm_reg[HYL_POS +: LIM_W] <= lim_reg[1];
      nvm_reg[HUL_POS +: LIM_W] <= lim_reg[2];
      nvm_reg[CTL_POS +: LIM_W] <= lim_reg[3];
      nvm_reg[NAM_POS +: LIM_W] <= dac_reg;
    end else if (base_store) begin
      nvm_reg[LTDV_POS +: LIM_W] <= dac_reg;
    end else if (sw_wr_lo) begin
      nvm_reg[31:0] <= sw_wdata;
    end else if (sw_wr_hi) begin
      nvm_reg[CFG_W-1:32] <= sw_wdata[CFG_W-33:0];
    end
  end
  logic nvm_wr_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) nvm_wr_reg <= 1'b0;
    else nvm_wr_reg <= setup_commit || ser_commit || lim_store || base_store;
  end

  // Error flag: raised as program enable falls, held until mode left
  logic cfg_err, err_mode, err_reg;
  logic [LIM_W-1:0] nl, hyl, nam;
  assign nl = nvm_reg[NL_POS +: LIM_W];
  assign hyl = nvm_reg[HYL_POS +: LIM_W];
  assign nam = nvm_reg[NAM_POS +: LIM_W];
  assign cfg_err = (hyl >= nl) || (nvm_reg[LTD_EN_POS] && nam <= nl);
  assign err_mode = active && mode_reg >= MODE_LIM_MAX && mode_reg <= MODE_BASE;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) err_reg <= 1'b0;
    else if (err_mode && io_fall && cfg_err && !leave) err_reg <= 1'b1;
    else if (leave || !active) err_reg <= 1'b0;
  end

  // Battery mode boost request, raised by the strobe
  logic boost_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) boost_reg <= 1'b0;
    else if (!active || mode_reg != MODE_BATT || leave) boost_reg <= 1'b0;
    else if (io_rise) boost_reg <= 1'b1;
  end

  // Pin outputs per mode; limit check compares against stored limit
  logic [LIM_W-1:0] chk_lim;
  always_comb begin
    case (mode_reg)
      4'ha: chk_lim = nl;
      4'hb: chk_lim = hyl;
      4'hc: chk_lim = nvm_reg[HUL_POS +: LIM_W];
      4'hd: chk_lim = nvm_reg[CTL_POS +: LIM_W];
      default: chk_lim = nam;
    endcase
  end
  logic horn_reg, red_reg, green_reg, view_reg;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      horn_reg <= 1'b0;
      red_reg <= 1'b0;
      green_reg <= 1'b0;
      view_reg <= 1'b0;
    end else begin
      red_reg <= active && mode_reg == MODE_BATT;
      green_reg <= active && mode_reg == MODE_BATT;
      view_reg <= in_lim || in_meas;
      if (!active) horn_reg <= 1'b0;
      else if (mode_reg == MODE_HORN) horn_reg <= tdata;
      else if (mode_reg == MODE_BATT) horn_reg <= boost_reg && batt_low;
      else if (in_lim) horn_reg <= smk_cmp;
      else if (mode_reg == MODE_SERIAL) horn_reg <= shift_reg[CFG_W-1];
      else if (in_chk) horn_reg <= meas_done_reg && (dac_reg > chk_lim);
      else horn_reg <= 1'b0;
    end
  end
  assign O_HORN_DRIVE_OUT = horn_reg;
  assign O_RED_INDICATOR_OUT = red_reg;
  assign O_GREEN_INDICATOR_OUT = green_reg;
  assign O_ANALOG_VIEW = view_reg;
  assign O_ERROR_FLAG_PIN = err_reg;
  assign O_BOOST_ENABLE = boost_reg;
  assign O_DAC_LEVEL = dac_reg;
  assign O_INTEGRATE_START = integ_start_reg;
  assign O_NVM_WRITE = nvm_wr_reg;

  // AHB-Lite slave, zero wait states, always OKAY
  logic ph_wr_reg, ph_valid_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] rdata_reg;
  logic addr_take;
  assign addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ph_valid_reg <= 1'b0;
      ph_wr_reg <= 1'b0;
      ph_addr_reg <= 8'h0;
    end else if (I_HREADY) begin
      ph_valid_reg <= addr_take;
      ph_wr_reg <= addr_take && I_HWRITE;
      ph_addr_reg <= I_HADDR[7:0];
    end
  end
  assign sw_wdata = I_HWDATA;
  assign sw_wr_lo = ph_wr_reg && ph_addr_reg == REG_CFG_LO;
  assign sw_wr_hi = ph_wr_reg && ph_addr_reg == REG_CFG_HI;
  // Read data captured at the address phase so it stands from a flop
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) rdata_reg <= 32'h0;
    else if (addr_take && !I_HWRITE) begin
      case (I_HADDR[7:0])
        REG_CFG_LO: rdata_reg <= nvm_reg[31:0];
        REG_CFG_HI: rdata_reg <= {6'h0, nvm_reg[CFG_W-1:32]};
        REG_STATUS: rdata_reg <= {22'h0, meas_done_reg, boost_reg, err_reg,
                                  active, mode_reg, 2'h0};
        REG_LIMITS: rdata_reg <= {2'h0, lim_reg[4], lim_reg[3], lim_reg[2],
                                  lim_reg[1], lim_reg[0]};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end
  assign O_HRDATA = rdata_reg;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  // Checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!rst_n);
  sequence s_second_pulse;
    lim_latch && mode_reg == MODE_LIM_MAX && pend_reg;
  endsequence
  a_mode_saturate: assert property (mode_reg <= MODE_LAST)
    else $error("mode beyond last");
  a_mode_step_one: assert property (mode_step |=> mode_reg == $past(mode_reg) + 4'h1)
    else $error("mode did not advance by one");
  a_exit_clears: assert property (!msel |=> ##1 (mode_reg == MODE_HORN && !err_reg))
    else $error("exit did not clear mode");
  a_err_modes_only: assert property (err_reg |-> mode_reg inside {[4'h7:4'h9]})
    else $error("error flag outside its modes");
  a_horn_follows: assert property (active && mode_reg == MODE_HORN && !leave
    |=> horn_reg == $past(tdata))
    else $error("horn not following enable");
  a_two_pulse_store: assert property (s_second_pulse |=> nvm_wr_reg)
    else $error("second pulse did not store");
  a_dac_step: assert property (in_lim && feed_rise && !leave && dac_reg != 6'h3f
    |=> dac_reg == $past(dac_reg) + 6'h1)
    else $error("dac did not step");
  a_setup_commit: assert property (setup_commit |=> nvm_wr_reg &&
    nvm_reg[57:36] == $past(shift_reg[21:0]))
    else $error("setup commit lost");
  a_batt_leds: assert property (active && mode_reg == MODE_BATT && !leave
    |=> red_reg && green_reg)
    else $error("battery mode leds off");
endmodule : tmpi_top
`default_nettype wire

// ### bench/tmpi_prog_model.sv
// Purpose: Programmer model that drives the test pins of the loader.
// Assumes: Every change lands just after a rising core clock edge.
// Notes: Feed link clock is 13 core cycles, 65 ns, only in frames.
`timescale 1ns/10ps
`default_nettype none
module tmpi_prog_model (
  input wire logic i_clk, // Core clock, paces every change
  output logic o_sel, // Mode select pin
  output logic o_boost, // Test pin at boost level
  output logic o_data, // Test pin data level
  output logic o_feed, // Feed pin, link clock
  output logic o_io // Interconnect pin
);
  // All pins at ground at power-up
  initial begin
    o_sel = 1'b0;
    o_boost = 1'b0;
    o_data = 1'b0;
    o_feed = 1'b0;
    o_io = 1'b0;
  end
  // Pace in core cycles, always ending just after an edge
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask : hold
  // Set levels, then leave room for the sync chain
  task automatic pins(input logic s, d, f, i);
    o_sel <= s;
    o_data <= d;
    o_feed <= f;
    o_io <= i;
    hold(8);
  endtask : pins
  // Test clock: swing to boost level and back to ground
  task automatic mode_clock();
    o_boost <= 1'b1;
    o_data <= 1'b1;
    hold(7);
    o_boost <= 1'b0;
    o_data <= 1'b0;
    hold(7);
  endtask : mode_clock
  // Shift n bits, highest first, data steady around each rise
  task automatic shift(input logic [57:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      o_data <= v[k];
      hold(3);
      o_feed <= 1'b1;
      hold(6);
      o_feed <= 1'b0;
      hold(4);
    end
    // Line no longer meaningful: show the inverse, not a stale bit
    o_data <= ~v[0];
    hold(3);
  endtask : shift
  // Train of interconnect pulses of a given high time
  task automatic commit(input int n, input int high);
    repeat (n) begin
      o_io <= 1'b1;
      hold(high);
      o_io <= 1'b0;
      hold(high);
    end
  endtask : commit
endmodule : tmpi_prog_model
`default_nettype wire

// ### bench/testbench.sv
// Purpose: Self-checking bench for the test-mode loader.
// Assumes: Programmer model drives the test pins; bench drives AHB-Lite, battery comparator and integrator code.
// Notes: Pulse length scaled down through PULSE_MIN to keep runs short.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tmpi_pkg::*;
  localparam int PMIN = 20; // Scaled least pulse high time
  logic clk = 1'b0; // Core clock, 200 MHz
  logic rst_n = 1'b0; // Reset, active low
  logic hsel = 1'b0, hwrite = 1'b0, bcmp = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [5:0] integ = 6'h00; // Integrator level code
  wire logic sel, boost, data, feed, io, red, green, horn, err, bst, aview;
  wire logic istart, nvm, hready, hresp;
  wire logic [5:0] dac;
  wire logic [31:0] hrdata;
  int num_errors = 0, checks_done = 0, cyc = 0, nvm_n = 0, int_n = 0;
  // Clock
  always #2.5 clk = ~clk;
  tmpi_prog_model prog (.i_clk(clk), .o_sel(sel), .o_boost(boost), .o_data(data),
    .o_feed(feed), .o_io(io));
  tmpi_top #(.PULSE_MIN(PMIN)) uut (.I_CLOCK(clk), .I_RESET_N(rst_n),
    .I_MODE_SELECT_PIN(sel), .I_TEST_BOOST(boost), .I_TEST_DATA(data), .I_FEED(feed),
    .I_IO(io), .I_BATTERY_COMPARATOR_OUT(bcmp), .I_INTEGRATOR_OUTPUT(integ),
    .O_RED_INDICATOR_OUT(red), .O_GREEN_INDICATOR_OUT(green), .O_HORN_DRIVE_OUT(horn),
    .O_ERROR_FLAG_PIN(err), .O_BOOST_ENABLE(bst), .O_ANALOG_VIEW(aview),
    .O_DAC_LEVEL(dac), .O_INTEGRATE_START(istart), .O_NVM_WRITE(nvm), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
    .O_HRESP(hresp));
  // Count one-cycle pulses; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (nvm === 1'b1) nvm_n++;
    if (istart === 1'b1) int_n++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // Word compare
  task automatic check_word(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word
  // Pin compare
  task automatic check_pin(input logic got, exp, input string what);
    check_word({31'h0, got}, {31'h0, exp}, what);
  endtask : check_pin
  // One single transfer; waits on ready, bounded by the cycle ceiling
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb
  // Idle pins, clean image, unmapped place reads zero
  task automatic t_reset();
    check_pin(horn, 1'b0, "horn idle");
    check_pin(hresp, 1'b0, "okay");
    ahb(1'b0, REG_CFG_LO, 32'h0);
    check_word(rd, 32'h0, "image reset");
    ahb(1'b1, 8'h10, 32'hffffffff);
    ahb(1'b0, 8'h10, 32'h0);
    check_word(rd, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset
  // Horn follows enable; then low battery mode
  task automatic t_horn_batt();
    prog.pins(1'b1, 1'b1, 1'b0, 1'b0);
    check_pin(horn, 1'b1, "horn on");
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    check_pin(horn, 1'b0, "horn off");
    prog.mode_clock();
    ahb(1'b0, REG_STATUS, 32'h0);
    check_word(rd & 32'h7c, 32'h44, "mode 1");
    check_pin(red & green, 1'b1, "leds on");
    bcmp <= 1'b1;
    prog.pins(1'b1, 1'b0, 1'b0, 1'b1);
    check_pin(bst, 1'b1, "boost");
    check_pin(horn, 1'b1, "battery high");
    bcmp <= 1'b0;
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    check_pin(horn, 1'b0, "battery low");
    $display("test horn and battery done");
  endtask : t_horn_batt
  // Setup load; commit only after the tenth pulse
  task automatic t_setup();
    int n0;
    n0 = nvm_n;
    prog.mode_clock();
    prog.shift({36'h0, 22'h1a5c3}, 22);
    prog.commit(9, PMIN + 2);
    check_word(32'(nvm_n - n0), 32'h0, "no early commit");
    prog.commit(1, PMIN + 2);
    check_word(32'(nvm_n - n0), 32'h1, "one commit");
    ahb(1'b0, REG_CFG_HI, 32'h0);
    check_word(rd, {6'h0, 22'h1a5c3, 4'h0}, "setup bits");
    $display("test setup done");
  endtask : t_setup
  // Limit mode: step, compare, integrate, latch without storing
  task automatic t_limit();
    int n0;
    integ <= 6'h04;
    prog.mode_clock();
    check_pin(aview, 1'b1, "analog view");
    check_word({26'h0, dac}, 32'h0, "dac start");
    check_pin(horn, 1'b1, "dac below");
    repeat (5) begin
      prog.pins(1'b1, 1'b0, 1'b1, 1'b0);
      prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    end
    check_word({26'h0, dac}, 32'h5, "dac stepped");
    check_pin(horn, 1'b0, "dac above");
    n0 = int_n;
    prog.pins(1'b1, 1'b0, 1'b1, 1'b0);
    prog.pins(1'b1, 1'b0, 1'b1, 1'b1);
    check_word(32'(int_n - n0), 32'h1, "integrate");
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    prog.pins(1'b1, 1'b0, 1'b0, 1'b1);
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    ahb(1'b0, REG_LIMITS, 32'h0);
    check_word(rd & 32'h3f, 32'h6, "held limit");
    ahb(1'b0, REG_CFG_HI, 32'h0);
    check_word(rd & 32'hf, 32'h0, "not stored");
    $display("test limit done");
  endtask : t_limit
  // Alarm-max: latch, then store on the second pulse; then a limit check
  task automatic t_store();
    int n0;
    repeat (4) prog.mode_clock();
    prog.pins(1'b1, 1'b0, 1'b1, 1'b0);
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    n0 = nvm_n;
    prog.commit(1, 8);
    check_word(32'(nvm_n - n0), 32'h0, "first pulse latches");
    prog.commit(1, 8);
    check_word(32'(nvm_n - n0), 32'h1, "second pulse stores");
    ahb(1'b0, REG_CFG_LO, 32'h0);
    check_word(rd, 32'h80000040, "limits stored");
    integ <= 6'h08;
    repeat (3) prog.mode_clock();
    check_pin(horn, 1'b0, "no result yet");
    prog.pins(1'b1, 1'b0, 1'b1, 1'b0);
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    check_word({26'h0, dac}, 32'h8, "measured");
    check_pin(horn, 1'b1, "above limit");
    $display("test store and check done");
  endtask : t_store
  // Leave, preload a bad image, serial commit flags it; mode saturates
  task automatic t_error();
    int n0;
    prog.pins(1'b0, 1'b0, 1'b0, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0);
    check_word(rd & 32'h7c, 32'h0, "session left");
    ahb(1'b1, REG_CFG_LO, 32'h05000000);
    prog.pins(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (8) prog.mode_clock();
    n0 = nvm_n;
    prog.commit(1, 8);
    check_pin(err, 1'b1, "error flag");
    check_word(32'(nvm_n - n0), 32'h1, "serial commit");
    repeat (8) prog.mode_clock();
    check_pin(err, 1'b0, "flag cleared");
    ahb(1'b0, REG_STATUS, 32'h0);
    check_word(rd & 32'hbc, 32'h38, "mode 14");
    $display("test error done");
  endtask : t_error
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_horn_batt();
    t_setup();
    t_limit();
    t_store();
    t_error();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
